// >>> rtl/mid_core.sv
// module: 14-bit instruction decoder and executor with avalon register slave
//
// Overview of operation
// - add wreg to file updates all arithmetic flags
// - destination bit 0 to wreg, 1 to file
// - and wreg with file updates zero only
// - or wreg with file updates zero flag
// - xor wreg with file updates zero flag
// - rotate left through carry, carry only
// - rotate right through carry, carry only
// - decrement, no flags, skip on zero
// - increment, no flags, skip on zero
// - bit test skips when bit clear
// - bit test skips when bit set
// - add literal to wreg, all arithmetic flags
// - or literal into wreg, zero flag
// - literal minus wreg into wreg, arithmetic flags
// - return with literal loads wreg, two cycles
// - return from interrupt pops, enables interrupts
// - return pops address, two cycles
// - kick watchdog clears timer, sets both power flags
// - standby entry sets time-out, clears sleep flag
// - port read-modify-write uses pin levels
// - timer zero write clears its prescaler
// - taken branch or skip adds nop cycle
// - clear bit clears selected file bit
// - set bit sets selected file bit
// - and literal into wreg, zero flag
// - clear file or wreg sets zero
`timescale 1ns/1ps
`default_nettype none
module mid_core
  import mid_pkg::*;
#(
  parameter int PC_W = 13
)
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [12:0] pmem_addr,
  input  wire logic [13:0] pmem_rd_data,
  input  wire logic [7:0]  port_pins,
  output logic      [7:0]  port_out,
  input  wire logic        prescaler_on_timer,
  output logic             prescaler_clr,
  output logic             wdog_clr,
  output logic             standby,
  input  wire logic        wake,
  output logic             gie_set,
  output logic             stack_push,
  output logic      [12:0] stack_push_addr,
  output logic             stack_pop,
  input  wire logic [12:0] stack_top
);
  // ---------------------------------------------------------------
  // state and file register array
  // ---------------------------------------------------------------
  mid_state_t s_r;
  mid_state_t s_nxt;
  logic [7:0] file_mem [128];
  logic       mem_we;
  logic [6:0] mem_wa;
  logic [7:0] mem_wd;

  logic [13:0] ir;
  logic [6:0]  fa;
  logic        dbit;
  logic [2:0]  bnum;
  logic [7:0]  lit;
  logic [7:0]  fval;
  logic [7:0]  res;
  logic [8:0]  sum9;
  logic [4:0]  sum5;
  logic        wr_dest;
  logic        skip;
  logic        exec;

  assign ir   = pmem_rd_data;
  assign fa   = ir[6:0];
  assign dbit = ir[7];
  assign bnum = ir[9:7];
  assign lit  = ir[7:0];
  assign exec = s_r.run && !s_r.standby && (s_r.phase == PHASE_LAST);

  // ---------------------------------------------------------------
  // file read, special addresses
  // ---------------------------------------------------------------
  always_comb
  begin
    if (fa == FA_STATUS)
    begin
      fval = {3'h0, s_r.to, s_r.slp, s_r.z, s_r.hc, s_r.c};
    end
    else if (fa == FA_PORT)
    begin
      fval = s_r.pin_sync;
    end
    else
    begin
      fval = file_mem[fa];
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_nxt           = s_r;
    mem_we          = 1'b0;
    mem_wa          = fa;
    mem_wd          = 8'h00;
    res             = 8'h00;
    sum9            = 9'h000;
    sum5            = 5'h00;
    wr_dest         = 1'b0;
    skip            = 1'b0;
    s_nxt.wdog_clr  = 1'b0;
    s_nxt.presc_clr = 1'b0;
    s_nxt.gie_set   = 1'b0;
    s_nxt.push      = 1'b0;
    s_nxt.pop       = 1'b0;
    s_nxt.pin_meta  = port_pins;
    s_nxt.pin_sync  = s_r.pin_meta;
    s_nxt.wake_meta = wake;
    s_nxt.wake_sync = s_r.wake_meta;

    if (s_r.run && !s_r.standby)
    begin
      s_nxt.phase = s_r.phase + 2'h1;
    end
    if (s_r.standby && s_r.wake_sync)
    begin
      s_nxt.standby = 1'b0;
    end

    if (exec)
    begin
      s_nxt.pc = s_r.pc + 13'h0001;
      if (s_r.flush)
      begin
        s_nxt.pc    = s_r.pc;
        s_nxt.flush = 1'b0;
      end
      else
      begin
        case (ir[13:12])
          2'b00:
          begin
            case (ir[11:8])
              OP_MOVWF_NOP:
              begin
                if (dbit)
                begin
                  res     = s_r.wreg;
                  wr_dest = 1'b1;
                end
                else if (ir == CW_RETURN)
                begin
                  s_nxt.pc    = stack_top;
                  s_nxt.pop   = 1'b1;
                  s_nxt.flush = 1'b1;
                end
                else if (ir == CW_RETFROMINT)
                begin
                  s_nxt.pc      = stack_top;
                  s_nxt.pop     = 1'b1;
                  s_nxt.gie_set = 1'b1;
                  s_nxt.flush   = 1'b1;
                end
                else if (ir == CW_KICK_WDOG)
                begin
                  s_nxt.wdog_clr = 1'b1;
                  s_nxt.to       = 1'b1;
                  s_nxt.slp      = 1'b1;
                end
                else if (ir == CW_STANDBY)
                begin
                  s_nxt.wdog_clr = 1'b1;
                  s_nxt.to       = 1'b1;
                  s_nxt.slp      = 1'b0;
                  s_nxt.standby  = 1'b1;
                end
              end
              OP_CLR:
              begin
                res     = 8'h00;
                wr_dest = dbit;
                s_nxt.z = 1'b1;
                if (!dbit)
                begin
                  s_nxt.wreg = 8'h00;
                end
              end
              OP_SUBWF, OP_ADD_F:
              begin
                if (ir[11:8] == OP_ADD_F)
                begin
                  sum9 = {1'b0, fval} + {1'b0, s_r.wreg};
                  sum5 = {1'b0, fval[3:0]} + {1'b0, s_r.wreg[3:0]};
                end
                else
                begin
                  sum9 = {1'b0, fval} + {1'b0, ~s_r.wreg} + 9'h001;
                  sum5 = {1'b0, fval[3:0]} + {1'b0, ~s_r.wreg[3:0]} + 5'h01;
                end
                res      = sum9[7:0];
                wr_dest  = 1'b1;
                s_nxt.c  = sum9[8];
                s_nxt.hc = sum5[4];
                s_nxt.z  = (res == 8'h00);
              end
              OP_DECF, OP_INCF, OP_COMF, OP_MOVF:
              begin
                if (ir[11:8] == OP_DECF)
                begin
                  res = fval - 8'h01;
                end
                else if (ir[11:8] == OP_INCF)
                begin
                  res = fval + 8'h01;
                end
                else if (ir[11:8] == OP_COMF)
                begin
                  res = ~fval;
                end
                else
                begin
                  res = fval;
                end
                wr_dest = 1'b1;
                s_nxt.z = (res == 8'h00);
              end
              OP_OR_F:
              begin
                res     = s_r.wreg | fval;
                wr_dest = 1'b1;
                s_nxt.z = (res == 8'h00);
              end
              OP_AND_F:
              begin
                res     = s_r.wreg & fval;
                wr_dest = 1'b1;
                s_nxt.z = (res == 8'h00);
              end
              OP_XOR_F:
              begin
                res     = s_r.wreg ^ fval;
                wr_dest = 1'b1;
                s_nxt.z = (res == 8'h00);
              end
              OP_ROL:
              begin
                res     = {fval[6:0], s_r.c};
                wr_dest = 1'b1;
                s_nxt.c = fval[7];
              end
              OP_ROR:
              begin
                res     = {s_r.c, fval[7:1]};
                wr_dest = 1'b1;
                s_nxt.c = fval[0];
              end
              OP_SWAPF:
              begin
                res     = {fval[3:0], fval[7:4]};
                wr_dest = 1'b1;
              end
              OP_DECSKP:
              begin
                res     = fval - 8'h01;
                wr_dest = 1'b1;
                skip    = (res == 8'h00);
              end
              default:
              begin
                res     = fval + 8'h01;
                wr_dest = 1'b1;
                skip    = (res == 8'h00);
              end
            endcase
            if (wr_dest && !dbit && ir[11:8] != OP_MOVWF_NOP && ir[11:8] != OP_CLR)
            begin
              s_nxt.wreg = res;
              wr_dest    = 1'b0;
            end
          end
          2'b01:
          begin
            case (ir[11:10])
              2'b00:
              begin
                res     = fval & ~(8'h01 << bnum);
                wr_dest = 1'b1;
              end
              2'b01:
              begin
                res     = fval | (8'h01 << bnum);
                wr_dest = 1'b1;
              end
              2'b10:
              begin
                skip = !fval[bnum];
              end
              default:
              begin
                skip = fval[bnum];
              end
            endcase
          end
          2'b10:
          begin
            if (!ir[11])
            begin
              s_nxt.push      = 1'b1;
              s_nxt.push_addr = s_r.pc + 13'h0001;
            end
            s_nxt.pc    = {s_r.pc[12:11], ir[10:0]};
            s_nxt.flush = 1'b1;
          end
          default:
          begin
            if (ir[11:10] == 2'b00)
            begin
              s_nxt.wreg = lit;
            end
            else if (ir[11:10] == 2'b01)
            begin
              s_nxt.wreg  = lit;
              s_nxt.pc    = stack_top;
              s_nxt.pop   = 1'b1;
              s_nxt.flush = 1'b1;
            end
            else if (ir[11:8] == 4'h8)
            begin
              s_nxt.wreg = s_r.wreg | lit;
              s_nxt.z    = ((s_r.wreg | lit) == 8'h00);
            end
            else if (ir[11:8] == 4'h9)
            begin
              s_nxt.wreg = s_r.wreg & lit;
              s_nxt.z    = ((s_r.wreg & lit) == 8'h00);
            end
            else if (ir[11:8] == 4'ha)
            begin
              s_nxt.wreg = s_r.wreg ^ lit;
              s_nxt.z    = ((s_r.wreg ^ lit) == 8'h00);
            end
            else
            begin
              if (ir[9])
              begin
                sum9 = {1'b0, lit} + {1'b0, s_r.wreg};
                sum5 = {1'b0, lit[3:0]} + {1'b0, s_r.wreg[3:0]};
              end
              else
              begin
                sum9 = {1'b0, lit} + {1'b0, ~s_r.wreg} + 9'h001;
                sum5 = {1'b0, lit[3:0]} + {1'b0, ~s_r.wreg[3:0]} + 5'h01;
              end
              s_nxt.wreg = sum9[7:0];
              s_nxt.c    = sum9[8];
              s_nxt.hc   = sum5[4];
              s_nxt.z    = (sum9[7:0] == 8'h00);
            end
          end
        endcase
        if (skip)
        begin
          s_nxt.pc    = s_r.pc + 13'h0002;
          s_nxt.flush = 1'b1;
        end
        if (wr_dest)
        begin
          mem_we = 1'b1;
          mem_wd = res;
          if (fa == FA_STATUS)
          begin
            s_nxt.c  = res[ST_C];
            s_nxt.hc = res[ST_HC];
            s_nxt.z  = res[ST_Z];
          end
          else if (fa == FA_PORT)
          begin
            s_nxt.port_latch = res;
          end
          else if (fa == FA_TIMER_ZERO && prescaler_on_timer)
          begin
            s_nxt.presc_clr = 1'b1;
          end
        end
      end
    end

    // avalon slave: one wait cycle, then answer
    s_nxt.ack = (avs_read || avs_write) && !s_r.ack;
    if ((avs_read || avs_write) && !s_r.ack)
    begin
      s_nxt.rdata = 32'h0000_0000;
      if (avs_address == OFS_CTRL)
      begin
        s_nxt.rdata[CTRL_RUN_BIT] = s_r.run;
      end
      else if (avs_address == OFS_WREG)
      begin
        s_nxt.rdata[7:0] = s_r.wreg;
      end
      else if (avs_address == OFS_STAT)
      begin
        s_nxt.rdata[5:0] = {s_r.standby, s_r.to, s_r.slp, s_r.z, s_r.hc, s_r.c};
      end
      else if (avs_address == OFS_PC)
      begin
        s_nxt.rdata[12:0] = s_r.pc;
      end
    end
    // write lands at the edge where waitrequest is seen low
    if (avs_write && s_r.ack && avs_address == OFS_CTRL && avs_byteenable[0])
    begin
      s_nxt.run   = avs_writedata[CTRL_RUN_BIT];
      s_nxt.phase = 2'h0;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_r       <= '0;
      s_r.pc    <= PC_RST;
      s_r.to    <= TO_RST;
      s_r.slp   <= SLP_RST;
      s_r.run   <= RUN_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (mem_we)
    begin
      file_mem[mem_wa] <= mem_wd;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign avs_waitrequest = (avs_read || avs_write) && !s_r.ack;
  assign avs_readdata    = s_r.rdata;
  assign pmem_addr       = s_r.pc;
  assign port_out        = s_r.port_latch;
  assign prescaler_clr   = s_r.presc_clr;
  assign wdog_clr        = s_r.wdog_clr;
  assign standby         = s_r.standby;
  assign gie_set         = s_r.gie_set;
  assign stack_push      = s_r.push;
  assign stack_push_addr = s_r.push_addr;
  assign stack_pop       = s_r.pop;
endmodule
`default_nettype wire

// >>> rtl/mid_pkg.sv
// package: constants and state type for the instruction decoder
package mid_pkg;
  // ---------------------------------------------------------------
  // clock and instruction cycle
  // ---------------------------------------------------------------
  localparam int          CLK_PERIOD_PS   = 4000;
  localparam int          OSC_PER_ICYC    = 4;
  localparam int          ICYC_PS         = OSC_PER_ICYC * CLK_PERIOD_PS;
  localparam int          CLK_PER_ICYC    = ICYC_PS / CLK_PERIOD_PS;
  localparam logic [1:0]  PHASE_LAST      = 2'(CLK_PER_ICYC - 1);
  // ---------------------------------------------------------------
  // avalon register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0]  OFS_CTRL        = 4'h0;
  localparam logic [3:0]  OFS_WREG        = 4'h4;
  localparam logic [3:0]  OFS_STAT        = 4'h8;
  localparam logic [3:0]  OFS_PC          = 4'hc;
  localparam int          CTRL_RUN_BIT    = 0;
  // ---------------------------------------------------------------
  // file register addresses and status bit positions
  // ---------------------------------------------------------------
  localparam logic [6:0]  FA_TIMER_ZERO   = 7'h01;
  localparam logic [6:0]  FA_STATUS       = 7'h03;
  localparam logic [6:0]  FA_PORT         = 7'h05;
  localparam int          ST_C            = 0;
  localparam int          ST_HC           = 1;
  localparam int          ST_Z            = 2;
  localparam int          ST_SLP          = 3;
  localparam int          ST_TO           = 4;
  // ---------------------------------------------------------------
  // byte operation codes, bits 11:8
  // ---------------------------------------------------------------
  localparam logic [3:0]  OP_MOVWF_NOP    = 4'h0;
  localparam logic [3:0]  OP_CLR          = 4'h1;
  localparam logic [3:0]  OP_SUBWF        = 4'h2;
  localparam logic [3:0]  OP_DECF         = 4'h3;
  localparam logic [3:0]  OP_OR_F         = 4'h4;
  localparam logic [3:0]  OP_AND_F        = 4'h5;
  localparam logic [3:0]  OP_XOR_F        = 4'h6;
  localparam logic [3:0]  OP_ADD_F        = 4'h7;
  localparam logic [3:0]  OP_MOVF         = 4'h8;
  localparam logic [3:0]  OP_COMF         = 4'h9;
  localparam logic [3:0]  OP_INCF         = 4'ha;
  localparam logic [3:0]  OP_DECSKP       = 4'hb;
  localparam logic [3:0]  OP_ROR          = 4'hc;
  localparam logic [3:0]  OP_ROL          = 4'hd;
  localparam logic [3:0]  OP_SWAPF        = 4'he;
  localparam logic [3:0]  OP_INCSKP       = 4'hf;
  // ---------------------------------------------------------------
  // control words
  // ---------------------------------------------------------------
  localparam logic [13:0] CW_RETURN       = 14'h0008;
  localparam logic [13:0] CW_RETFROMINT   = 14'h0009;
  localparam logic [13:0] CW_KICK_WDOG    = 14'h0064;
  localparam logic [13:0] CW_STANDBY      = 14'h0063;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [12:0] PC_RST          = 13'h0000;
  localparam logic        TO_RST          = 1'b1;
  localparam logic        SLP_RST         = 1'b1;
  localparam logic        RUN_RST         = 1'b0;

  typedef struct packed {
    logic [1:0]  phase;
    logic [12:0] pc;
    logic [7:0]  wreg;
    logic        c;
    logic        hc;
    logic        z;
    logic        to;
    logic        slp;
    logic        flush;
    logic        standby;
    logic        run;
    logic        ack;
    logic [31:0] rdata;
    logic [7:0]  pin_meta;
    logic [7:0]  pin_sync;
    logic        wake_meta;
    logic        wake_sync;
    logic [7:0]  port_latch;
    logic        wdog_clr;
    logic        presc_clr;
    logic        gie_set;
    logic        push;
    logic        pop;
    logic [12:0] push_addr;
  } mid_state_t;
endpackage

// >>> tb/mid_pmem.sv
// program memory and return stack model at the decoder's fetch side
`timescale 1ns/1ps
`default_nettype none
module mid_pmem
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [12:0] pmem_addr,
  output logic      [13:0] pmem_rd_data,
  input  wire logic        stack_push,
  input  wire logic [12:0] stack_push_addr,
  input  wire logic        stack_pop,
  output logic      [12:0] stack_top
);
  // ---------------------------------------------------------------
  // word store and eight-deep return stack
  // ---------------------------------------------------------------
  logic [13:0] mem [32];
  logic [12:0] stk [8];
  logic [2:0]  sp;
  assign pmem_rd_data = (pmem_addr < 13'h0020) ? mem[pmem_addr[4:0]] : 14'h0000;
  assign stack_top    = stk[sp - 3'h1];
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      sp <= 3'h0;
    else if (stack_push)
    begin
      stk[sp] <= stack_push_addr;
      sp      <= sp + 3'h1;
    end
    else if (stack_pop)
      sp <= sp - 3'h1;
endmodule
`default_nettype wire

// >>> tb/mid_checker.sv
// port-level assertions for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module mid_checker
  import mid_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic        avs_waitrequest,
  input  wire logic [12:0] pmem_addr,
  input  wire logic [13:0] pmem_rd_data,
  input  wire logic        prescaler_on_timer,
  input  wire logic        prescaler_clr,
  input  wire logic        wdog_clr,
  input  wire logic        gie_set,
  input  wire logic        stack_push,
  input  wire logic [12:0] stack_push_addr,
  input  wire logic        stack_pop,
  input  wire logic [12:0] stack_top
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_req_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_was_call;
    $past(pmem_rd_data[13:11]) == 3'b100;
  endsequence
  property p_one_wait;
    s_req_wait |=> !avs_waitrequest;
  endproperty
  property p_idle;
    !(avs_read || avs_write) |-> !avs_waitrequest;
  endproperty
  property p_push;
    stack_push |-> s_was_call ##0 stack_push_addr == $past(pmem_addr) + 13'h0001;
  endproperty
  property p_call_pc;
    stack_push |-> pmem_addr[10:0] == $past(pmem_rd_data[10:0]);
  endproperty
  property p_pop;
    stack_pop |-> $past(pmem_rd_data) == CW_RETURN || $past(pmem_rd_data) == CW_RETFROMINT
                  || $past(pmem_rd_data[13:10]) == 4'b1101;
  endproperty
  property p_pop_pc;
    stack_pop |-> pmem_addr == $past(stack_top);
  endproperty
  property p_gie;
    gie_set |-> $past(pmem_rd_data) == CW_RETFROMINT ##1 !gie_set;
  endproperty
  property p_wdog;
    wdog_clr |-> ($past(pmem_rd_data) == CW_KICK_WDOG || $past(pmem_rd_data) == CW_STANDBY) ##1 !wdog_clr;
  endproperty
  property p_presc;
    prescaler_clr |-> $past(prescaler_on_timer) && $past(pmem_rd_data[6:0]) == FA_TIMER_ZERO;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("waitrequest held past one cycle");
  a_idle: assert property (p_idle) else $error("waitrequest without request");
  a_push: assert property (p_push) else $error("push without call");
  a_call_pc: assert property (p_call_pc) else $error("call target wrong");
  a_pop: assert property (p_pop) else $error("pop without return");
  a_pop_pc: assert property (p_pop_pc) else $error("return address wrong");
  a_gie: assert property (p_gie) else $error("interrupt enable pulse wrong");
  a_wdog: assert property (p_wdog) else $error("watchdog clear pulse wrong");
  a_presc: assert property (p_presc) else $error("prescaler clear wrong");
endmodule
bind mid_core mid_checker chk_u (.core_clk(core_clk), .nrst(nrst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .pmem_addr(pmem_addr), .pmem_rd_data(pmem_rd_data),
  .prescaler_on_timer(prescaler_on_timer), .prescaler_clr(prescaler_clr), .wdog_clr(wdog_clr),
  .gie_set(gie_set), .stack_push(stack_push), .stack_push_addr(stack_push_addr), .stack_pop(stack_pop),
  .stack_top(stack_top));
`default_nettype wire

// >>> tb/tb_midrange_instruction_decoder.sv
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module tb_midrange_instruction_decoder;
  import mid_pkg::*;
  // ---------------------------------------------------------------
  // signals, model and design
  // ---------------------------------------------------------------
  logic        core_clk, nrst, avs_read, avs_write, prescaler_on_timer, wake;
  logic        avs_waitrequest, prescaler_clr, wdog_clr, standby, gie_set, stack_push, stack_pop;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  logic [12:0] pmem_addr, stack_push_addr, stack_top;
  logic [13:0] pmem_rd_data;
  logic [7:0]  port_pins, port_out, a, b;
  logic [13:0] prog [$];
  logic [31:0] exp_q [$];
  logic [3:0]  ops [5] = '{OP_ADD_F, OP_AND_F, OP_OR_F, OP_XOR_F, OP_ADD_F};
  int          n_fail, comparisons;
  mid_pmem pm_u (.core_clk(core_clk), .nrst(nrst), .pmem_addr(pmem_addr), .pmem_rd_data(pmem_rd_data),
    .stack_push(stack_push), .stack_push_addr(stack_push_addr), .stack_pop(stack_pop), .stack_top(stack_top));
  mid_core dut_u (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pmem_addr(pmem_addr),
    .pmem_rd_data(pmem_rd_data), .port_pins(port_pins), .port_out(port_out), .prescaler_on_timer(prescaler_on_timer),
    .prescaler_clr(prescaler_clr), .wdog_clr(wdog_clr), .standby(standby), .wake(wake), .gie_set(gie_set),
    .stack_push(stack_push), .stack_push_addr(stack_push_addr), .stack_pop(stack_pop), .stack_top(stack_top));
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  function automatic logic [10:0] falu(input logic sub, input logic [7:0] x, input logic [7:0] y);
    logic [8:0] s;
    logic       h;
    s = sub ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
    h = sub ? (x[3:0] >= y[3:0]) : (({1'b0, x[3:0]} + {1'b0, y[3:0]}) > 5'h0f);
    return {s[7:0] == 8'h00, h, s[8] ^ sub, s[7:0]};
  endfunction
  function automatic logic [10:0] lgc(input logic [7:0] v);
    return {v == 8'h00, 2'b00, v};
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task bus(input logic wr, input logic [3:0] ad, input logic [31:0] d);
    @(posedge core_clk);
    avs_address   <= ad;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task expect_rd(input logic [3:0] ad, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, ad, 32'h0);
  endtask
  task run_prog(input logic [10:0] r, input int cyc);
    prog.push_back(14'h2800 | 14'(prog.size()));
    nrst <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 32; i++)
      pm_u.mem[i] = (i < prog.size()) ? prog[i] : 14'h0000;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    bus(1'b1, OFS_CTRL, 32'h1);
    repeat (cyc) @(posedge core_clk);
    expect_rd(OFS_WREG, {24'h0, r[7:0]});
    expect_rd(OFS_STAT, {26'h0, 1'b0, TO_RST, SLP_RST, r[10:8]});
    prog.delete();
    $display("test done w=%h", r[7:0]);
  endtask
  always @(posedge core_clk)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      chk(avs_readdata, exp_q.pop_front());
  initial
  begin
    repeat (6000) @(posedge core_clk);
    n_fail++;
    tally_and_finish;
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    nrst = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 4'h0; avs_writedata = 32'h0;
    avs_byteenable = 4'hf; prescaler_on_timer = 1'b1; wake = 1'b0;
    void'($urandom(96083));
    port_pins = 8'($urandom);
    for (int m = 0; m < 4; m++)
    begin
      a = 8'($urandom);
      b = (m == 3) ? 8'(-a) : 8'($urandom);
      prog = '{14'h3000 | a, (m[0] ? 14'h3c00 : 14'h3e00) | b};
      run_prog(falu(m[0], b, a), 40);
    end
    for (int i = 0; i < 5; i++)
    begin
      a = 8'($urandom);
      b = 8'($urandom);
      prog = '{14'h3000 | a, 14'h00a0, 14'h3000 | b, {2'b00, ops[i], i == 4, 7'h20}};
      if (i == 4)
        prog.push_back(14'h0820);
      run_prog(i == 1 ? lgc(a & b) : i == 2 ? lgc(a | b) : i == 3 ? lgc(a ^ b) : falu(1'b0, a, b), 60);
    end
    a = 8'($urandom);
    b = 8'($urandom);
    prog = '{14'h3001, 14'h00a0, 14'h3000 | a, 14'h0ba0, 14'h3855, 14'h00a1, 14'h0081, CW_KICK_WDOG,
             14'h200c, 14'h0721, 14'h280a, 14'h0000, 14'h200e, CW_RETFROMINT, 14'h3400 | b};
    run_prog(falu(1'b0, b, a), 160);
    a = 8'($urandom) & 8'hfe;
    prog = '{14'h3000 | a, 14'h00a0, 14'h1420, 14'h1c20, 14'h0103, 14'h0c20, 14'h1020, 14'h1820, 14'h0103};
    run_prog({3'b001, 1'b0, a[7:1]}, 80);
    prog = '{14'h3000 | {6'h00, ~port_pins}, 14'h0085, 14'h0885};
    run_prog({port_pins == 8'h00, 2'b00, ~port_pins}, 60);
    chk({24'h0, port_out}, {24'h0, port_pins});
    expect_rd(4'h2, 32'h0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
